// ===== verilog/fcd_top.sv
// float / coprocessor operate dispatch with an AXI4-Lite register port
// assumes one clock; the float unit and coprocessor answer with done
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fcd_top
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus write
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // register bus read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // operation fields to both units
   output logic [8:0] op_code,
   output logic [4:0] first_source_field,
   output logic [4:0] second_source_field,
   output logic [4:0] dest_field,
   // float unit
   input wire logic fpu_present,
   output logic fpu_issue,
   output logic [3:0] fpu_kind,
   input wire logic fpu_done,
   input wire logic [1:0] fpu_relation,
   input wire logic fpu_snan,
   input wire logic fpu_qnan,
   input wire logic overflow_flag,
   input wire logic underflow_flag,
   input wire logic inexact_flag,
   input wire logic bad_operation_flag,
   output logic [1:0] float_unit_cond_lines,
   // coprocessor
   input wire logic coproc_attached_line,
   output logic cp_issue,
   output logic cp_class_two,
   input wire logic cp_done,
   input wire logic cp_error,
   input wire logic cp_cc_valid,
   input wire logic [1:0] cp_cc,
   output logic [1:0] coproc_cond_lines,
   // trap requests to the integer unit
   output logic float_unit_off_trap,
   output logic float_error_trap,
   output logic bad_float_reg_trap,
   output logic coproc_off_trap,
   output logic coproc_error_trap
);
   // ************************************************
   // state
   // ************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CHECK = 3'b010,
      ST_WAIT = 3'b100
   } fcd_run_e;

   typedef struct packed {
      fcd_run_e st;
      logic [31:0] insn;
      logic [1:0] ctrl;
      logic [1:0] fcc;
      logic [1:0] ccc;
      logic [4:0] traps;
      logic unimpl;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic fpu_issue;
      logic cp_issue;
      logic [4:0] pulse;
   } fcd_state_s;

   fcd_state_s q_ff;
   fcd_state_s nxt_q;
   logic wr_take;
   logic rd_take;
   logic ferr;
   logic fe_ok;
   logic ec_ok;
   // class two differs from class one in the low function bit
   localparam int MF_LSB_SEL = fcd_pkg::MF_LO;

   fcd_dec_if dif ();

   // decoder sees the held instruction word
   assign dif.insn = q_ff.insn;

   fcd_decode u_dec
   (
      .dif(dif)
   );

   // handshake terms: write address and data are taken together
   assign wr_take = s_axi_awvalid && s_axi_wvalid && !q_ff.bvalid;
   assign rd_take = s_axi_arvalid && !q_ff.rvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = !q_ff.rvalid;

   // enable gates combine software bits with presence lines
   assign fe_ok = q_ff.ctrl[fcd_pkg::CTRL_FE] && fpu_present;
   assign ec_ok = q_ff.ctrl[fcd_pkg::CTRL_EC] && coproc_attached_line;

   // ************************************************
   // next state
   // ************************************************
   always_comb
   begin
      nxt_q = q_ff;
      ferr = 1'b0;
      nxt_q.fpu_issue = 1'b0;
      nxt_q.cp_issue = 1'b0;
      nxt_q.pulse = 5'h0;

      // register writes; a new word is refused while one is in flight
      if (wr_take)
      begin
         nxt_q.bvalid = 1'b1;
         nxt_q.bresp = fcd_pkg::RESP_OKAY;
         case (s_axi_awaddr)
            fcd_pkg::ADDR_CTRL:
               if (s_axi_wstrb[0])
                  nxt_q.ctrl = s_axi_wdata[1:0];
            fcd_pkg::ADDR_INSN:
               if (q_ff.st == ST_IDLE)
               begin
                  for (int b = 0; b < 4; b++)
                     if (s_axi_wstrb[b])
                        nxt_q.insn[8*b +: 8] = s_axi_wdata[8*b +: 8];
                  nxt_q.st = ST_CHECK;
                  nxt_q.traps = 5'h0;
                  nxt_q.unimpl = 1'b0;
               end
               else
                  nxt_q.bresp = fcd_pkg::RESP_SLVERR;
            fcd_pkg::ADDR_STAT: nxt_q.bresp = fcd_pkg::RESP_OKAY;
            default: nxt_q.bresp = fcd_pkg::RESP_SLVERR;
         endcase
      end
      else if (q_ff.bvalid && s_axi_bready)
         nxt_q.bvalid = 1'b0;

      // register reads
      if (rd_take)
      begin
         nxt_q.rvalid = 1'b1;
         nxt_q.rresp = fcd_pkg::RESP_OKAY;
         case (s_axi_araddr)
            fcd_pkg::ADDR_CTRL: nxt_q.rdata = {30'h0, q_ff.ctrl};
            fcd_pkg::ADDR_INSN: nxt_q.rdata = q_ff.insn;
            fcd_pkg::ADDR_STAT:
               nxt_q.rdata = {21'h0, q_ff.unimpl, q_ff.traps, q_ff.ccc, q_ff.fcc,
                  q_ff.st != ST_IDLE};
            default:
            begin
               nxt_q.rdata = 32'h0;
               nxt_q.rresp = fcd_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (q_ff.rvalid && s_axi_rready)
         nxt_q.rvalid = 1'b0;

      // dispatch: enable checks come before any issue
      unique case (q_ff.st)
         ST_IDLE:
         begin
         end
         ST_CHECK:
         begin
            nxt_q.st = ST_IDLE;
            if (dif.uses_float && !fe_ok)
               nxt_q.pulse[fcd_pkg::TR_FOFF] = 1'b1;
            else if (dif.uses_cp && !ec_ok)
               nxt_q.pulse[fcd_pkg::TR_COFF] = 1'b1;
            else if (dif.bad_reg)
               nxt_q.pulse[fcd_pkg::TR_BADR] = 1'b1;
            else if (dif.uses_float)
            begin
               nxt_q.fpu_issue = 1'b1;
               nxt_q.st = ST_WAIT;
            end
            else if (dif.uses_cp)
            begin
               nxt_q.cp_issue = 1'b1;
               nxt_q.st = ST_WAIT;
            end
            else
               nxt_q.unimpl = 1'b1;
         end
         ST_WAIT:
         begin
            if (dif.uses_float && fpu_done)
            begin
               nxt_q.st = ST_IDLE;
               case (dif.kind)
                  fcd_pkg::KIND_ADD, fcd_pkg::KIND_SUB:
                     ferr = overflow_flag || underflow_flag || inexact_flag ||
                        bad_operation_flag;
                  fcd_pkg::KIND_MUL, fcd_pkg::KIND_DIV:
                     ferr = overflow_flag || underflow_flag || inexact_flag ||
                        bad_operation_flag;
                  fcd_pkg::KIND_WMUL:
                     ferr = bad_operation_flag;
                  fcd_pkg::KIND_CMP, fcd_pkg::KIND_CMPE:
                  begin
                     // unordered whenever either operand is a NaN
                     nxt_q.fcc = (fpu_snan || fpu_qnan) ? fcd_pkg::FCC_UNORD
                        : fpu_relation;
                     ferr = fpu_snan ||
                        (dif.kind == fcd_pkg::KIND_CMPE && fpu_qnan);
                  end
                  default: ferr = 1'b0;
               endcase
               nxt_q.pulse[fcd_pkg::TR_FERR] = ferr;
            end
            else if (dif.uses_cp && cp_done)
            begin
               nxt_q.st = ST_IDLE;
               if (dif.kind == fcd_pkg::KIND_CP2 && cp_cc_valid)
                  nxt_q.ccc = cp_cc;
               nxt_q.pulse[fcd_pkg::TR_CERR] = cp_error;
            end
         end
      endcase

      // trap bits stay up until the next word is launched
      nxt_q.traps = nxt_q.traps | nxt_q.pulse;
   end

   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q_ff <= '0;
         q_ff.st <= ST_IDLE;
         q_ff.ctrl <= fcd_pkg::CTRL_RST;
      end
      else
         q_ff <= nxt_q;
   end

   // ************************************************
   // outputs
   // ************************************************
   assign s_axi_bvalid = q_ff.bvalid;
   assign s_axi_bresp = q_ff.bresp;
   assign s_axi_rvalid = q_ff.rvalid;
   assign s_axi_rdata = q_ff.rdata;
   assign s_axi_rresp = q_ff.rresp;
   assign op_code = q_ff.insn[fcd_pkg::OPF_HI:fcd_pkg::OPF_LO];
   assign first_source_field = q_ff.insn[fcd_pkg::RS1_HI:fcd_pkg::RS1_LO];
   assign second_source_field = q_ff.insn[fcd_pkg::RS2_HI:fcd_pkg::RS2_LO];
   assign dest_field = q_ff.insn[fcd_pkg::RD_HI:fcd_pkg::RD_LO];
   assign fpu_issue = q_ff.fpu_issue;
   assign fpu_kind = dif.kind;
   assign cp_issue = q_ff.cp_issue;
   assign cp_class_two = q_ff.insn[MF_LSB_SEL];
   assign float_unit_cond_lines = q_ff.fcc;
   assign coproc_cond_lines = q_ff.ccc;
   assign float_unit_off_trap = q_ff.pulse[fcd_pkg::TR_FOFF];
   assign float_error_trap = q_ff.pulse[fcd_pkg::TR_FERR];
   assign bad_float_reg_trap = q_ff.pulse[fcd_pkg::TR_BADR];
   assign coproc_off_trap = q_ff.pulse[fcd_pkg::TR_COFF];
   assign coproc_error_trap = q_ff.pulse[fcd_pkg::TR_CERR];

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_fp_off;
      q_ff.st == ST_CHECK && dif.uses_float && !fe_ok |=> float_unit_off_trap && !fpu_issue
         ##1 !fpu_issue;
   endproperty
   a_fp_off: assert property (p_fp_off) else $error("float off did not trap");

   property p_cp_off;
      q_ff.st == ST_CHECK && dif.uses_cp && !ec_ok |=> coproc_off_trap && !cp_issue;
   endproperty
   a_cp_off: assert property (p_cp_off) else $error("coproc off did not trap");

   property p_bad_reg;
      q_ff.st == ST_CHECK && fe_ok && dif.bad_reg |=> bad_float_reg_trap && !fpu_issue;
   endproperty
   a_bad_reg: assert property (p_bad_reg) else $error("misaligned register issued");

   property p_add_issue;
      fpu_issue && fpu_kind == fcd_pkg::KIND_ADD |-> $past(q_ff.st) == ST_CHECK
         && !dif.bad_reg && fe_ok;
   endproperty
   a_add_issue: assert property (p_add_issue) else $error("add issued wrongly");

   property p_wmul_exact;
      q_ff.st == ST_WAIT && fpu_kind == fcd_pkg::KIND_WMUL && fpu_done
         && !bad_operation_flag |=> !float_error_trap;
   endproperty
   a_wmul_exact: assert property (p_wmul_exact) else $error("exact multiply trapped");

   property p_cmp_unord;
      q_ff.st == ST_WAIT && dif.kind inside {fcd_pkg::KIND_CMP, fcd_pkg::KIND_CMPE}
         && fpu_done && (fpu_snan || fpu_qnan) |=> float_unit_cond_lines == 2'h3;
   endproperty
   a_cmp_unord: assert property (p_cmp_unord) else $error("unordered code wrong");

   property p_cmpe_nv;
      q_ff.st == ST_WAIT && dif.kind == fcd_pkg::KIND_CMPE && fpu_done && fpu_qnan
         |=> float_error_trap;
   endproperty
   a_cmpe_nv: assert property (p_cmpe_nv) else $error("quiet NaN not trapped");

   property p_cmp_quiet;
      q_ff.st == ST_WAIT && dif.kind == fcd_pkg::KIND_CMP && fpu_done && !fpu_snan
         |=> !float_error_trap;
   endproperty
   a_cmp_quiet: assert property (p_cmp_quiet) else $error("plain compare trapped");

   property p_cp1_cc;
      q_ff.st == ST_WAIT && dif.kind == fcd_pkg::KIND_CP1 && cp_done
         |=> $stable(coproc_cond_lines);
   endproperty
   a_cp1_cc: assert property (p_cp1_cc) else $error("class one changed codes");

   c_cmp_done: cover property (q_ff.st == ST_WAIT && dif.kind == fcd_pkg::KIND_CMPE && fpu_done);
   c_cp2_done: cover property (q_ff.st == ST_WAIT && dif.kind == fcd_pkg::KIND_CP2 && cp_done);
   c_fp_off: cover property (float_unit_off_trap);
endmodule

// ===== verilog/fcd_pkg.sv
// float / coprocessor operate decode: shared constants and types
// assumes a 32-bit instruction word and a 32-bit register bus
package fcd_pkg;
   // ************************************************
   // instruction word layout
   // ************************************************
   localparam int OP_HI = 31;
   localparam int OP_LO = 30;
   localparam int RD_HI = 29;
   localparam int RD_LO = 25;
   localparam int MF_HI = 24;
   localparam int MF_LO = 19;
   localparam int RS1_HI = 18;
   localparam int RS1_LO = 14;
   localparam int OPF_HI = 13;
   localparam int OPF_LO = 5;
   localparam int RS2_HI = 4;
   localparam int RS2_LO = 0;
   localparam logic [1:0] FMT_OPERATE = 2'h2;
   localparam logic [5:0] MF_FLOAT = 6'h34;
   localparam logic [5:0] MF_CMP = 6'h35;
   localparam logic [5:0] MF_CP1 = 6'h36;
   localparam logic [5:0] MF_CP2 = 6'h37;
   // operation groups: operation field bits 8..2
   localparam logic [6:0] GRP_ADD = 7'h10;
   localparam logic [6:0] GRP_SUB = 7'h11;
   localparam logic [6:0] GRP_MUL = 7'h12;
   localparam logic [6:0] GRP_DIV = 7'h13;
   localparam logic [6:0] GRP_CMP = 7'h14;
   localparam logic [6:0] GRP_CMPE = 7'h15;
   localparam logic [8:0] OPF_SMULD = 9'h069;
   localparam logic [8:0] OPF_DMULQ = 9'h06E;
   localparam logic [1:0] PREC_S = 2'h1;
   localparam logic [1:0] PREC_D = 2'h2;
   localparam logic [1:0] PREC_Q = 2'h3;
   localparam logic [1:0] FCC_UNORD = 2'h3;
   // ************************************************
   // register map and fields
   // ************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INSN = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam int CTRL_FE = 0;
   localparam int CTRL_EC = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int TR_FOFF = 0;
   localparam int TR_FERR = 1;
   localparam int TR_BADR = 2;
   localparam int TR_COFF = 3;
   localparam int TR_CERR = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      KIND_NONE = 4'h0, KIND_ADD = 4'h1, KIND_SUB = 4'h2, KIND_MUL = 4'h3,
      KIND_WMUL = 4'h4, KIND_DIV = 4'h5, KIND_CMP = 4'h6, KIND_CMPE = 4'h7,
      KIND_CP1 = 4'h8, KIND_CP2 = 4'h9
   } fcd_kind_e;
endpackage

// ===== verilog/fcd_dec_if.sv
// carrier between the control logic and the instruction decoder
// assumes the decoder is purely combinational
`timescale 1ns/1ps
interface fcd_dec_if;
   logic [31:0] insn;
   fcd_pkg::fcd_kind_e kind;
   logic [1:0] prec;
   logic uses_float;
   logic uses_cp;
   logic bad_reg;
   modport dec (input insn, output kind, prec, uses_float, uses_cp, bad_reg);
   modport user (output insn, input kind, prec, uses_float, uses_cp, bad_reg);
endinterface

// ===== verilog/fcd_decode.sv
// combinational decoder of float and coprocessor operate words
// assumes the word is held stable by the caller
`timescale 1ns/1ps
module fcd_decode
(
   // decode carrier
   fcd_dec_if.dec dif
);
   // misaligned register number for a precision
   function automatic logic misaligned(input logic [4:0] r, input logic [1:0] p);
      return (p == fcd_pkg::PREC_D && r[0]) || (p == fcd_pkg::PREC_Q && r[1:0] != 2'h0);
   endfunction

   logic [8:0] opf;
   logic [5:0] mf;
   logic [1:0] src_p;
   logic [1:0] dst_p;
   logic chk_rd;
   assign opf = dif.insn[fcd_pkg::OPF_HI:fcd_pkg::OPF_LO];
   assign mf = dif.insn[fcd_pkg::MF_HI:fcd_pkg::MF_LO];

   // classify the word and check register alignment
   always_comb
   begin
      dif.kind = fcd_pkg::KIND_NONE;
      src_p = fcd_pkg::PREC_S;
      dst_p = fcd_pkg::PREC_S;
      chk_rd = 1'b1;
      if (dif.insn[fcd_pkg::OP_HI:fcd_pkg::OP_LO] == fcd_pkg::FMT_OPERATE)
      begin
         if (mf == fcd_pkg::MF_FLOAT && opf == fcd_pkg::OPF_SMULD)
         begin
            dif.kind = fcd_pkg::KIND_WMUL;
            dst_p = fcd_pkg::PREC_D;
         end
         else if (mf == fcd_pkg::MF_FLOAT && opf == fcd_pkg::OPF_DMULQ)
         begin
            dif.kind = fcd_pkg::KIND_WMUL;
            src_p = fcd_pkg::PREC_D;
            dst_p = fcd_pkg::PREC_Q;
         end
         else if (mf == fcd_pkg::MF_FLOAT && opf[1:0] != 2'h0)
         begin
            src_p = opf[1:0];
            dst_p = opf[1:0];
            case (opf[8:2])
               fcd_pkg::GRP_ADD: dif.kind = fcd_pkg::KIND_ADD;
               fcd_pkg::GRP_SUB: dif.kind = fcd_pkg::KIND_SUB;
               fcd_pkg::GRP_MUL: dif.kind = fcd_pkg::KIND_MUL;
               fcd_pkg::GRP_DIV: dif.kind = fcd_pkg::KIND_DIV;
               default: dif.kind = fcd_pkg::KIND_NONE;
            endcase
         end
         else if (mf == fcd_pkg::MF_CMP && opf[1:0] != 2'h0)
         begin
            src_p = opf[1:0];
            chk_rd = 1'b0; // destination unused in compares
            case (opf[8:2])
               fcd_pkg::GRP_CMP: dif.kind = fcd_pkg::KIND_CMP;
               fcd_pkg::GRP_CMPE: dif.kind = fcd_pkg::KIND_CMPE;
               default: dif.kind = fcd_pkg::KIND_NONE;
            endcase
         end
         else if (mf == fcd_pkg::MF_CP1)
            dif.kind = fcd_pkg::KIND_CP1;
         else if (mf == fcd_pkg::MF_CP2)
            dif.kind = fcd_pkg::KIND_CP2;
      end
      dif.uses_cp = dif.kind inside {fcd_pkg::KIND_CP1, fcd_pkg::KIND_CP2};
      dif.uses_float = dif.kind != fcd_pkg::KIND_NONE && !dif.uses_cp;
      dif.prec = dst_p;
      // single precision never misaligns, so single forms are exempt
      dif.bad_reg = dif.uses_float &&
         (misaligned(dif.insn[fcd_pkg::RS1_HI:fcd_pkg::RS1_LO], src_p) ||
          misaligned(dif.insn[fcd_pkg::RS2_HI:fcd_pkg::RS2_LO], src_p) ||
          (chk_rd && misaligned(dif.insn[fcd_pkg::RD_HI:fcd_pkg::RD_LO], dst_p)));
   end
endmodule

// ===== tb/fcd_unit_model.sv
// far-side model: float unit and coprocessor answering issue pulses
// assumes one-cycle issue pulses; the bench sets the results to return
`timescale 1ns/1ps
module fcd_unit_model
(
   // clock
   input wire logic aclk,
   // issue from the block
   input wire logic fpu_issue,
   input wire logic cp_issue,
   // settings from the bench
   input wire logic present,
   input wire logic attached,
   input wire logic slow,
   input wire logic [11:0] res,
   // answers to the block
   output logic fpu_done,
   output logic cp_done,
   output logic fpu_present,
   output logic coproc_attached_line,
   output logic [11:0] res_o
);
   logic [2:0] fd = 3'h0;
   logic [2:0] cd = 3'h0;
   // presence lines follow the bench's choice
   assign fpu_present = present;
   assign coproc_attached_line = attached;
   // done one or three cycles after the issue pulse
   always @(posedge aclk)
   begin
      fd <= {fd[1:0], fpu_issue};
      cd <= {cd[1:0], cp_issue};
   end
   assign fpu_done = slow ? fd[2] : fd[0];
   assign cp_done = slow ? cd[2] : cd[0];
   // results valid only beside done, inverted otherwise
   assign res_o = (fpu_done | cp_done) ? res : ~res;
endmodule

// ===== tb/fp_coproc_operate_decode_test.sv
// self-checking bench for the float / coprocessor operate dispatch
// assumes fcd_top with its unit model and an AXI4-Lite master here
`timescale 1ns/1ps
module fp_coproc_operate_decode_test;
   logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat;
   logic awr, wr_, bv, arr, rv, fi, ci, cls, fdn, cdn, fp, ca, lcls, clr = 1'h0;
   logic [1:0] br, rr, fcl, ccl;
   logic [3:0] kd;
   logic [8:0] opc;
   logic [4:0] s1, s2, dd, tr;
   logic present = 1'h1, attached = 1'h0, slow = 1'h0;
   logic [11:0] res = 12'h0, ro;
   logic [6:0] seen = 7'h00;
   logic [27:0] lat = 28'h0;
   int fails = 0, n_tests = 0;
   // ************************************************
   // clock, dut and model
   // ************************************************
   always #4 aclk = ~aclk;
   fcd_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr), .op_code(opc),
      .first_source_field(s1), .second_source_field(s2), .dest_field(dd), .fpu_present(fp),
      .fpu_issue(fi), .fpu_kind(kd), .fpu_done(fdn), .fpu_relation(ro[11:10]),
      .fpu_snan(ro[9]), .fpu_qnan(ro[8]), .overflow_flag(ro[7]), .underflow_flag(ro[6]),
      .inexact_flag(ro[5]), .bad_operation_flag(ro[4]), .float_unit_cond_lines(fcl),
      .coproc_attached_line(ca), .cp_issue(ci), .cp_class_two(cls), .cp_done(cdn),
      .cp_error(ro[3]), .cp_cc_valid(ro[2]), .cp_cc(ro[1:0]), .coproc_cond_lines(ccl),
      .float_unit_off_trap(tr[0]), .float_error_trap(tr[1]), .bad_float_reg_trap(tr[2]),
      .coproc_off_trap(tr[3]), .coproc_error_trap(tr[4]));
   fcd_unit_model u_model (.aclk(aclk), .fpu_issue(fi), .cp_issue(ci), .present(present),
      .attached(attached), .slow(slow), .res(res), .fpu_done(fdn), .cp_done(cdn),
      .fpu_present(fp), .coproc_attached_line(ca), .res_o(ro));
   // gather issue and trap pulses, latch fields at each float issue
   always @(posedge aclk)
   begin
      seen <= clr ? 7'h00 : seen | {tr, ci, fi};
      if (fi === 1'h1) lat <= {kd, opc, s1, s2, dd};
      if (ci === 1'h1) lcls <= cls;
   end
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      do @(posedge aclk); while (!(awr === 1'h1 && wr_ === 1'h1));
      awv <= 1'h0;
      wv <= 1'h0;
      bry <= 1'h1;
      do @(posedge aclk); while (bv !== 1'h1);
      r = br;
      bry <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      ara <= a;
      arv <= 1'h1;
      do @(posedge aclk); while (arr !== 1'h1);
      arv <= 1'h0;
      rry <= 1'h1;
      do @(posedge aclk); while (rv !== 1'h1);
      d = rdat;
      r = rr;
      rry <= 1'h0;
   endtask
   function automatic logic [31:0] mk(logic [5:0] mf, logic [4:0] d, logic [4:0] a,
      logic [8:0] o, logic [4:0] b);
      return {2'h2, d, mf, a, o, b};
   endfunction
   // launch one word, poll busy, then judge pulses and issued fields
   task automatic op(input logic [31:0] w, input logic [11:0] rv_, input logic [6:0] es,
      input logic [3:0] ek);
      logic [1:0] r;
      logic [31:0] s;
      int n;
      res <= rv_;
      clr <= 1'h1;
      @(posedge aclk);
      clr <= 1'h0;
      wr(8'h04, w, r);
      chk("insn resp", {30'h0, fcd_pkg::RESP_OKAY}, {30'h0, r});
      n = 0;
      do rd(8'h08, s, r); while (s[0] !== 1'h0 && ++n < 40);
      chk("busy", 32'h0, {31'h0, s[0]});
      chk("pulses", {25'h0, es}, {25'h0, seen});
      if (es[0]) chk("fields", {ek, w[13:5], w[18:14], w[4:0], w[29:25]}, lat);
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rd(8'h00, d, r);
      chk("ctrl reset", 32'h0, d);
      rd(8'h08, d, r);
      chk("status reset", 32'h0, d);
      rd(8'h0C, d, r);
      chk("unmapped resp", {30'h0, fcd_pkg::RESP_SLVERR}, {30'h0, r});
      wr(8'h08, 32'hFFFFFFFF, r);
      chk("status wr resp", {30'h0, fcd_pkg::RESP_OKAY}, {30'h0, r});
      rd(8'h08, d, r);
      chk("status read only", 32'h0, d);
      wr(8'h0C, 32'h0, r);
      chk("unmapped wr resp", {30'h0, fcd_pkg::RESP_SLVERR}, {30'h0, r});
      wr(8'h04, 32'h80000000, r);
      rd(8'h08, d, r);
      chk("unimpl", 32'h00000400, d);
   endtask
   task automatic t_off;
      logic [1:0] r;
      wr(8'h00, 32'h0, r);
      op(mk(fcd_pkg::MF_FLOAT, 5'h2, 5'h4, 9'h041, 5'h6), 12'h0, 7'h04, 4'h0);
      op(mk(fcd_pkg::MF_CP1, 5'h2, 5'h4, 9'h041, 5'h6), 12'h0, 7'h20, 4'h0);
      present <= 1'h0;
      wr(8'h00, 32'h1, r);
      op(mk(fcd_pkg::MF_FLOAT, 5'h2, 5'h4, 9'h049, 5'h6), 12'h0, 7'h04, 4'h0);
      present <= 1'h1;
      wr(8'h00, 32'h3, r);
      op(mk(fcd_pkg::MF_CP2, 5'h2, 5'h4, 9'h041, 5'h6), 12'h0, 7'h20, 4'h0);
   endtask
   task automatic t_arith;
      for (int i = 0; i < 12; i++)
         op(mk(fcd_pkg::MF_FLOAT, 5'h4, 5'h8, {7'(16 + i / 3), 2'(i % 3 + 1)}, 5'hC), 12'h0,
            7'h01, 4'(i / 3 + 1 + (i / 3 == 3)));
      for (int j = 0; j < 4; j++)
         op(mk(fcd_pkg::MF_FLOAT, 5'h4, 5'h8, 9'h045, 5'hC), 12'h010 << j, 7'h09, 4'h2);
      op(mk(fcd_pkg::MF_FLOAT, 5'h4, 5'h9, 9'h069, 5'hB), 12'h0E0, 7'h01, 4'h4);
      op(mk(fcd_pkg::MF_FLOAT, 5'h4, 5'h8, 9'h06E, 5'hC), 12'h0E0, 7'h01, 4'h4);
   endtask
   task automatic t_badreg;
      op(mk(fcd_pkg::MF_FLOAT, 5'h4, 5'h9, 9'h042, 5'hC), 12'h0, 7'h10, 4'h1);
      op(mk(fcd_pkg::MF_FLOAT, 5'h5, 5'h9, 9'h041, 5'h3), 12'h0, 7'h01, 4'h1);
      op(mk(fcd_pkg::MF_FLOAT, 5'h4, 5'h8, 9'h047, 5'hE), 12'h0, 7'h10, 4'h2);
      op(mk(fcd_pkg::MF_CMP, 5'h0, 5'h9, 9'h052, 5'hC), 12'h0, 7'h10, 4'h6);
      op(mk(fcd_pkg::MF_CMP, 5'h0, 5'h9, 9'h055, 5'h3), 12'h0, 7'h01, 4'h7);
   endtask
   task automatic t_cmp;
      logic [1:0] r;
      logic [31:0] d;
      slow <= 1'h1;
      for (int i = 0; i < 6; i++)
      begin
         op(mk(fcd_pkg::MF_CMP, 5'h0, 5'h8, {7'(20 + i / 3), 2'(i % 3 + 1)}, 5'hC),
            {2'(i % 3), 10'h0}, 7'h01, 4'(6 + i / 3));
         chk("fcc", 32'(i % 3), {30'h0, fcl});
      end
      op(mk(fcd_pkg::MF_CMP, 5'h0, 5'h8, 9'h051, 5'hC), 12'h100, 7'h01, 4'h6);
      chk("fcc", 32'h3, {30'h0, fcl});
      op(mk(fcd_pkg::MF_CMP, 5'h0, 5'h8, 9'h051, 5'hC), 12'h200, 7'h09, 4'h6);
      op(mk(fcd_pkg::MF_CMP, 5'h0, 5'h8, 9'h055, 5'hC), 12'h100, 7'h09, 4'h7);
      wr(8'h04, mk(fcd_pkg::MF_CMP, 5'h0, 5'h8, 9'h051, 5'hC), r);
      wr(8'h04, 32'h0, r);
      chk("busy insn resp", {30'h0, fcd_pkg::RESP_SLVERR}, {30'h0, r});
      repeat (8) @(posedge aclk);
      rd(8'h04, d, r);
      chk("busy insn kept", mk(fcd_pkg::MF_CMP, 5'h0, 5'h8, 9'h051, 5'hC), d);
      slow <= 1'h0;
   endtask
   task automatic t_cp;
      logic [1:0] r;
      attached <= 1'h1;
      op(mk(fcd_pkg::MF_CP1, 5'h3, 5'h5, 9'h1A5, 5'h7), 12'h006, 7'h02, 4'h0);
      chk("cp codes", 32'h0, {30'h0, ccl});
      chk("cp class", 32'h0, {31'h0, lcls});
      op(mk(fcd_pkg::MF_CP2, 5'h3, 5'h5, 9'h1A5, 5'h7), 12'h006, 7'h02, 4'h0);
      chk("cp codes", 32'h2, {30'h0, ccl});
      chk("cp class", 32'h1, {31'h0, lcls});
      op(mk(fcd_pkg::MF_CP2, 5'h3, 5'h5, 9'h0F0, 5'h7), 12'h00D, 7'h42, 4'h0);
      wr(8'h00, 32'h1, r);
      op(mk(fcd_pkg::MF_CP1, 5'h3, 5'h5, 9'h0F0, 5'h7), 12'h0, 7'h20, 4'h0);
   endtask
   // reset, scenarios, verdict
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs();
      t_off();
      t_arith();
      t_badreg();
      t_cmp();
      t_cp();
      tally_and_finish();
   end
   // watchdog against a hung handshake
   initial
   begin
      #400000;
      fails++;
      tally_and_finish();
   end
endmodule
